// >>> logic/rceq_top.sv
/*
 remote command error queue and system settings block with a plain register port.
 assumes the command parser and the register master run on i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rceq_top
	import rceq_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int NRANGE = 4,
	parameter logic [31:0] VERSION_ID = 32'h00010000 // arbitrary value
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire rceq_cmd_report_t i_report,
	output rceq_net_t o_net,
	output logic o_link_drop,
	output logic o_power_on_last
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_C = CW'(1);
	localparam logic [PW-1:0] PTR_ONE = PW'(1);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [15:0] fifo_reg [DEPTH];
	logic [15:0] fifo_next [DEPTH];
	logic [PW-1:0] rptr_reg, rptr_next, wptr_reg, wptr_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [15:0] last_reg, last_next;
	logic [31:0] excl_reg [NRANGE];
	logic [31:0] excl_next [NRANGE];
	logic [NRANGE-1:0] excl_en_reg, excl_en_next;
	logic pwr_reg, pwr_next;
	rceq_net_t pend_reg, pend_next, act_reg, act_next;
	logic drop_reg, drop_next;
	logic [31:0] rdata_reg, rdata_next;

	logic err_valid;
	logic [15:0] err_code;
	logic excluded;
	logic push, pop, clr;
	logic ip_ok;

	////////////////////////////////////////////////////////////////////////////////
	// error classification and ip checks
	always_comb begin
		err_valid = 1'b0;
		err_code = ERR_NONE;
		ip_ok = (i_wdata[31:24] >= IP_OCT_MIN) && (i_wdata[31:24] <= IP_OCT_MAX)
			&& (i_wdata[31:24] != IP_OCT_LOOP);
		if (i_report.done) begin
			err_valid = 1'b1;
			if (i_report.len > CMD_MAX_LEN) begin
				err_code = ERR_CODE_A;
			end else if (i_report.bad_char) begin
				err_code = ERR_CODE_B;
			end else if (!i_report.terminated || !i_report.header_ok) begin
				err_code = ERR_CODE_F;
			end else if (i_report.needs_param && !i_report.has_param) begin
				err_code = ERR_CODE_C;
			end else if (i_report.out_of_range) begin
				err_code = ERR_CODE_D;
			end else if (i_report.prohibited) begin
				err_code = ERR_CODE_E;
			end else begin
				err_valid = 1'b0;
			end
		end else if (i_wr && i_addr == ADDR_IP) begin
			if (!act_reg.manual) begin
				err_valid = 1'b1;
				err_code = ERR_CODE_E;
			end else if (!ip_ok) begin
				err_valid = 1'b1;
				err_code = ERR_CODE_D;
			end
		end
	end

	always_comb begin
		excluded = 1'b0;
		for (int i = 0; i < NRANGE; i++) begin
			if (excl_en_reg[i]
				&& $signed(err_code) >= $signed(excl_reg[i][EXCL_LO_LSB +: 16])
				&& $signed(err_code) <= $signed(excl_reg[i][EXCL_HI_LSB +: 16])) begin
				excluded = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// error queue next state
	always_comb begin
		fifo_next = fifo_reg;
		rptr_next = rptr_reg;
		wptr_next = wptr_reg;
		cnt_next = cnt_reg;
		last_next = last_reg;
		clr = i_wr && i_addr == ADDR_CMD
			&& (i_wdata[CMD_QCLR_BIT] || i_wdata[CMD_SYSCLR_BIT]);
		// a clear in the same cycle wins over the pop
		// read pops head
		pop = i_rd && i_addr == ADDR_ERR_POP && cnt_reg != '0 && !clr;
		push = err_valid && !excluded && (clr || cnt_reg != DEPTH_C || pop);
		if (clr) begin
			rptr_next = '0;
			wptr_next = '0;
			cnt_next = '0;
		end
		if (pop) begin
			rptr_next = rptr_reg + PTR_ONE;
		end
		if (push) begin
			// a new error in the clearing cycle survives the clear
			fifo_next[clr ? '0 : wptr_reg] = err_code;
			wptr_next = clr ? PTR_ONE : wptr_reg + PTR_ONE;
			last_next = err_code;
		end
		if (!clr) begin
			cnt_next = cnt_reg + (push ? ONE_C : '0) - (pop ? ONE_C : '0);
		end else if (push) begin
			cnt_next = ONE_C;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// exclusion next state
	always_comb begin
		excl_next = excl_reg;
		excl_en_next = excl_en_reg;
		if (i_wr) begin
			if (i_addr == ADDR_EXCL_EN) begin
				excl_en_next = i_wdata[NRANGE-1:0];
			end
			for (int i = 0; i < NRANGE; i++) begin
				if (i_addr == ADDR_EXCL_BASE + 8'(4 * i)) begin
					excl_next[i] = i_wdata;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// settings next state
	always_comb begin
		pwr_next = pwr_reg;
		pend_next = pend_reg;
		act_next = act_reg;
		drop_next = 1'b0;
		if (i_wr) begin
			unique case (i_addr)
				ADDR_CMD: begin
					if (i_wdata[CMD_APPLY_BIT]) begin
						act_next = pend_reg;
						drop_next = 1'b1;
					end
				end
				ADDR_PWRON: pwr_next = i_wdata[0];
				ADDR_NET_CFG: begin
					pend_next.dhcp = i_wdata[NET_DHCP_BIT];
					pend_next.manual = i_wdata[NET_MAN_BIT];
				end
				ADDR_IP: begin
					if (act_reg.manual && ip_ok) begin
						pend_next.ip = i_wdata;
					end
				end
				default: drop_next = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data next state
	always_comb begin
		rdata_next = WORD_ZERO;
		if (i_rd) begin
			unique case (i_addr)
				ADDR_CMD: begin
					rdata_next[CW-1:0] = cnt_reg;
					rdata_next[STAT_EMPTY_BIT] = cnt_reg == '0;
					rdata_next[STAT_FULL_BIT] = cnt_reg == DEPTH_C;
				end
				ADDR_EXCL_EN: rdata_next[NRANGE-1:0] = excl_en_reg;
				ADDR_ERR_POP: begin
					if (cnt_reg != '0) begin
						rdata_next[15:0] = fifo_reg[rptr_reg];
					end
				end
				ADDR_ERR_LAST: rdata_next[15:0] = last_reg;
				ADDR_VERSION: rdata_next = VERSION_ID;
				ADDR_PWRON: rdata_next[0] = pwr_reg;
				ADDR_NET_CFG: begin
					rdata_next[NET_DHCP_BIT] = pend_reg.dhcp;
					rdata_next[NET_MAN_BIT] = pend_reg.manual;
				end
				ADDR_IP: rdata_next = pend_reg.ip;
				ADDR_NET_ACT: begin
					rdata_next[NET_DHCP_BIT] = act_reg.dhcp;
					rdata_next[NET_MAN_BIT] = act_reg.manual;
				end
				ADDR_IP_ACT: rdata_next = act_reg.ip;
				default: begin
					for (int i = 0; i < NRANGE; i++) begin
						if (i_addr == ADDR_EXCL_BASE + 8'(4 * i)) begin
							rdata_next = excl_reg[i];
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// error queue registers
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				fifo_reg[i] <= ERR_NONE;
			end
			rptr_reg <= '0;
			wptr_reg <= '0;
			cnt_reg <= '0;
			last_reg <= ERR_NONE;
		end else begin
			fifo_reg <= fifo_next;
			rptr_reg <= rptr_next;
			wptr_reg <= wptr_next;
			cnt_reg <= cnt_next;
			last_reg <= last_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// exclusion registers
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < NRANGE; i++) begin
				excl_reg[i] <= WORD_ZERO;
			end
			excl_en_reg <= '0;
		end else begin
			excl_reg <= excl_next;
			excl_en_reg <= excl_en_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// settings registers
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_reg <= 1'b0;
			pend_reg <= '{dhcp: 1'b0, manual: 1'b0, ip: IP_RESET};
			act_reg <= '{dhcp: 1'b0, manual: 1'b0, ip: IP_RESET};
			drop_reg <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			pend_reg <= pend_next;
			act_reg <= act_next;
			drop_reg <= drop_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data register
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_reg <= WORD_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata = rdata_reg;
	assign o_net = act_reg;
	assign o_link_drop = drop_reg;
	assign o_power_on_last = pwr_reg;
endmodule
`default_nettype wire

// >>> logic/rceq_pkg.sv
/*
 holds the shared constants and carriers of the remote command error queue block.
 assumes a single 10 MHz clock domain and a same-clock command parser as the source of reports.
*/
`default_nettype none
package rceq_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_EXCL_EN = 8'h08;
	localparam logic [7:0] ADDR_ERR_POP = 8'h0C;
	localparam logic [7:0] ADDR_EXCL_BASE = 8'h10;
	localparam logic [7:0] ADDR_ERR_LAST = 8'h20;
	localparam logic [7:0] ADDR_VERSION = 8'h24;
	localparam logic [7:0] ADDR_PWRON = 8'h28;
	localparam logic [7:0] ADDR_NET_CFG = 8'h2C;
	localparam logic [7:0] ADDR_IP = 8'h30;
	localparam logic [7:0] ADDR_NET_ACT = 8'h34;
	localparam logic [7:0] ADDR_IP_ACT = 8'h38;
	// command register bits
	localparam int CMD_QCLR_BIT = 0;
	localparam int CMD_SYSCLR_BIT = 1;
	localparam int CMD_APPLY_BIT = 2;
	// net config bits
	localparam int NET_DHCP_BIT = 0;
	localparam int NET_MAN_BIT = 1;
	// status fields in the command register read
	localparam int STAT_EMPTY_BIT = 8;
	localparam int STAT_FULL_BIT = 9;
	// exclusion range word layout
	localparam int EXCL_LO_LSB = 0;
	localparam int EXCL_HI_LSB = 16;
	// longest accepted command
	localparam logic [7:0] CMD_MAX_LEN = 8'h0F;
	// ip first octet limits
	localparam logic [7:0] IP_OCT_MIN = 8'h01;
	localparam logic [7:0] IP_OCT_MAX = 8'hDF;
	localparam logic [7:0] IP_OCT_LOOP = 8'h7F;
	// error codes reported for the six classes
	localparam logic [15:0] ERR_CODE_A = 16'hFF90;
	localparam logic [15:0] ERR_CODE_B = 16'hFF9B;
	localparam logic [15:0] ERR_CODE_C = 16'hFF93;
	localparam logic [15:0] ERR_CODE_D = 16'hFF22;
	localparam logic [15:0] ERR_CODE_E = 16'hFF23;
	localparam logic [15:0] ERR_CODE_F = 16'hFF8F;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	// reset values
	localparam logic [31:0] IP_RESET = 32'h00000000;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	typedef struct packed {
		logic done;
		logic [7:0] len;
		logic bad_char;
		logic needs_param;
		logic has_param;
		logic out_of_range;
		logic prohibited;
		logic terminated;
		logic header_ok;
	} rceq_cmd_report_t;

	typedef struct packed {
		logic dhcp;
		logic manual;
		logic [31:0] ip;
	} rceq_net_t;
endpackage
`default_nettype wire

// >>> testbench/rceq_props.sv
/*
 port checker of the error queue block.
 assumes a bind onto rceq_top in the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module rceq_props import rceq_pkg::*; #(parameter logic [31:0] VERSION_ID = 32'h00000000) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire rceq_net_t o_net,
	input wire logic o_link_drop,
	input wire logic o_power_on_last
);
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	logic apl;
	logic pwr_wr;
	assign apl = i_wr && i_addr == ADDR_CMD && i_wdata[CMD_APPLY_BIT];
	assign pwr_wr = i_wr && i_addr == ADDR_PWRON;
	////////////////////////////////////////////////////////////////
	property p_ver; i_rd && i_addr == ADDR_VERSION |=> o_rdata == VERSION_ID; endproperty
	property p_drop; apl |=> o_link_drop ##1 !o_link_drop; endproperty
	property p_nodrop; !apl |=> !o_link_drop; endproperty
	property p_hold; !apl |=> $stable(o_net); endproperty
	property p_pwr; pwr_wr |=> o_power_on_last == $past(i_wdata[0]); endproperty
	property p_pwrk; !pwr_wr |=> $stable(o_power_on_last); endproperty
	property p_pwrrd; i_rd && i_addr == ADDR_PWRON |=> o_rdata == {31'h0, $past(o_power_on_last)}; endproperty
	property p_act; i_rd && i_addr == ADDR_IP_ACT |=> o_rdata == $past(o_net.ip); endproperty
	property p_idle; !i_rd |=> o_rdata == WORD_ZERO; endproperty
	a_ver: assert property (p_ver) else $error("version read wrong");
	a_drop: assert property (p_drop) else $error("link drop pulse wrong");
	a_nodrop: assert property (p_nodrop) else $error("link drop without apply");
	a_hold: assert property (p_hold) else $error("network moved without apply");
	a_pwr: assert property (p_pwr) else $error("power-on select not taken");
	a_pwrk: assert property (p_pwrk) else $error("power-on select moved");
	a_pwrrd: assert property (p_pwrrd) else $error("power-on read wrong");
	a_act: assert property (p_act) else $error("active ip read wrong");
	a_idle: assert property (p_idle) else $error("read data not idle");
	c_apl: cover property (apl);
	c_pwr: cover property (pwr_wr);
	c_ver: cover property (i_rd && i_addr == ADDR_VERSION);
endmodule
`default_nettype wire

// >>> testbench/rceq_host.sv
/*
 remote host model driving finished command reports.
 assumes the report port samples on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rceq_host import rceq_pkg::*; (
	input wire logic i_ref_clk,
	output var rceq_cmd_report_t o_report
);
	initial o_report = '0;
	task automatic send(input logic [7:0] len, input logic [6:0] f);
		@(posedge i_ref_clk);
		o_report <= {1'b1, len, f};
		@(posedge i_ref_clk);
		o_report <= {1'b0, ~len, ~f};
	endtask
endmodule
`default_nettype wire

// >>> testbench/rceq_top_tb_top.sv
/*
 self-checking bench of the error queue block.
 assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rceq_top_tb_top import rceq_pkg::*;;
	localparam logic [31:0] VID = 32'h00010000; // arbitrary value
	logic i_ref_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	rceq_cmd_report_t rep;
	rceq_net_t o_net;
	logic o_link_drop;
	logic o_power_on_last;
	int n_fail = 0;
	int checks = 0;
	logic [6:0] ft [6] = '{7'h03, 7'h43, 7'h23, 7'h0B, 7'h07, 7'h02};
	logic [15:0] ct [6] = '{ERR_CODE_A, ERR_CODE_B, ERR_CODE_C, ERR_CODE_D, ERR_CODE_E, ERR_CODE_F};
	rceq_top #(.VERSION_ID(VID)) dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_report(rep),
		.o_net(o_net), .o_link_drop(o_link_drop), .o_power_on_last(o_power_on_last));
	rceq_host host (.i_ref_clk(i_ref_clk), .o_report(rep));
	initial begin
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= dv;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		chk($sformatf("rd %h", a), o_rdata, e);
	endtask
	task automatic err(input int i);
		host.send(i == 0 ? 8'h14 : 8'h05, ft[i]);
	endtask
	task automatic end_sim;
		$display("checks %0d fails %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_cls;
		rdc(ADDR_CMD, 32'h00000100);
		rdc(ADDR_ERR_LAST, 32'h00000000);
		rdc(ADDR_NET_ACT, 32'h00000000);
		wr(ADDR_CMD, 32'h00000001);
		for (int i = 0; i < 6; i++) begin
			err(i);
			rdc(ADDR_ERR_LAST, {16'h0000, ct[i]});
			rdc(ADDR_ERR_POP, {16'h0000, ct[i]});
		end
		host.send(8'h0F, 7'h03);
		rdc(ADDR_CMD, 32'h00000100);
		$display("t_cls done");
	endtask
	task automatic t_fifo;
		for (int i = 0; i < 9; i++) err(i % 6);
		rdc(ADDR_CMD, 32'h00000208);
		rdc(ADDR_ERR_LAST, {16'h0000, ct[1]});
		rdc(ADDR_ERR_POP, {16'h0000, ct[0]});
		rdc(ADDR_ERR_POP, {16'h0000, ct[1]});
		rdc(ADDR_CMD, 32'h00000006);
		wr(ADDR_CMD, 32'h00000001);
		rdc(ADDR_CMD, 32'h00000100);
		err(0);
		wr(ADDR_CMD, 32'h00000002);
		rdc(ADDR_CMD, 32'h00000100);
		$display("t_fifo done");
	endtask
	task automatic t_excl;
		wr(ADDR_EXCL_BASE, 32'hFF92FF22);
		rdc(ADDR_EXCL_BASE, 32'hFF92FF22);
		wr(ADDR_EXCL_EN, 32'h00000001);
		for (int i = 0; i < 6; i++) err(i);
		rdc(ADDR_CMD, 32'h00000002);
		rdc(ADDR_ERR_POP, {16'h0000, ct[1]});
		rdc(ADDR_ERR_POP, {16'h0000, ct[2]});
		wr(ADDR_EXCL_BASE + 8'h04, 32'h0384FE48);
		wr(ADDR_EXCL_EN, 32'h00000002);
		for (int i = 0; i < 6; i++) err(i);
		rdc(ADDR_CMD, 32'h00000100);
		wr(ADDR_EXCL_EN, 32'h00000000);
		$display("t_excl done");
	endtask
	task automatic t_pwr;
		wr(ADDR_PWRON, 32'h00000001);
		rdc(ADDR_PWRON, 32'h00000001);
		chk("pwr", {31'h0, o_power_on_last}, 32'h00000001);
		wr(ADDR_PWRON, 32'h00000000);
		rdc(ADDR_PWRON, 32'h00000000);
		rdc(ADDR_VERSION, VID);
		$display("t_pwr done");
	endtask
	task automatic t_net;
		wr(ADDR_NET_CFG, 32'h00000003);
		rdc(ADDR_NET_ACT, 32'h00000000);
		rdc(ADDR_NET_CFG, 32'h00000003);
		wr(ADDR_CMD, 32'h00000004);
		rdc(ADDR_NET_ACT, 32'h00000003);
		wr(ADDR_IP, 32'h7F000001);
		wr(ADDR_IP, 32'hE0000001);
		wr(ADDR_IP, 32'h00000001);
		rdc(ADDR_CMD, 32'h00000003);
		wr(ADDR_IP, 32'h01000000);
		rdc(ADDR_IP, 32'h01000000);
		wr(ADDR_IP, 32'hDF010203);
		rdc(ADDR_IP_ACT, 32'h00000000);
		wr(ADDR_CMD, 32'h00000004);
		@(negedge i_ref_clk);
		chk("ip", o_net.ip, 32'hDF010203);
		wr(ADDR_NET_CFG, 32'h00000000);
		wr(ADDR_CMD, 32'h00000005);
		wr(ADDR_IP, 32'h0A000001);
		rdc(ADDR_IP, 32'hDF010203);
		rdc(ADDR_ERR_POP, {16'h0000, ERR_CODE_E});
		$display("t_net done");
	endtask
	initial begin
		#1000000;
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		t_cls;
		t_fifo;
		t_excl;
		t_pwr;
		t_net;
		end_sim;
	end
endmodule
bind rceq_top rceq_props #(.VERSION_ID(VERSION_ID)) u_props (.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_net(o_net), .o_link_drop(o_link_drop),
	.o_power_on_last(o_power_on_last));
`default_nettype wire
